// ### design/gpio_link_pkg.sv
// Constants and types shared by the serializer pin link port
package gpio_link_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_REMOTE_DATA = 8'h0D;
  localparam logic [7:0] ADDR_DIR_CTRL = 8'h0E;
  localparam logic [7:0] ADDR_FWD_COUNT = 8'h33;
  localparam logic [7:0] ADDR_PIN_STATUS = 8'h53;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 4;
  localparam int DIR_IN_LSB = 0;
  localparam int DIR_OUT_LSB = 4;
  localparam int LOCAL_VAL_LSB = 0;
  localparam int REMOTE_SEL_LSB = 4;
  localparam int FWD_COUNT_LSB = 0;
  localparam int FWD_COUNT_W = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DIR_CTRL_RST = 8'h0F;
  localparam logic [7:0] REMOTE_DATA_RST = 8'h00;
  localparam logic [7:0] FWD_COUNT_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Forward sampling periods, in forward frames
  // ----------------------------------------------------------------
  localparam logic [2:0] FWD_PERIOD_ONE = 3'h1;
  localparam logic [2:0] FWD_PERIOD_TWO = 3'h2;
  localparam logic [2:0] FWD_PERIOD_MANY = 3'h5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int FS_SKEW_NS = 600;
  localparam int FS_SKEW_CYC = FS_SKEW_NS / CLK_PERIOD_NS;
  localparam int BC_TO_PIN_CYC = 2;

  typedef enum logic [1:0] {
    FWD_OFF = 2'b00,
    FWD_ONE = 2'b01,
    FWD_TWO = 2'b10,
    FWD_MANY = 2'b11
  } fwd_mode_t;

endpackage

// ### design/pin_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int W = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage3_r;
  logic [W-1:0] held_r;
  logic [W-1:0] held_nxt;

  // Take a change only once stages two and three agree
  assign held_nxt = (stage2_r & ~(stage2_r ^ stage3_r)) | (held_r & (stage2_r ^ stage3_r));
  assign syncOut = held_r;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
      held_r <= '0;
    end else if (ce) begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      held_r <= held_nxt;
    end
  end

endmodule // pin_sync3

// ### design/serializer_gpio_link_port.sv
// Four-pin general purpose port with forward and back channel tunnelling
`timescale 1ns/1ps
module serializer_gpio_link_port (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic [3:0] pinIn,
  output logic [3:0] pinOut,
  output logic [3:0] pinOe,
  output logic [3:0] pinPullDown,
  input wire logic [1:0] analogSenseSel,
  output logic [1:0] analogSenseEn,
  input wire logic fwdFrameClk,
  output logic fwdFrameStrobe,
  output logic [3:0] fwdPinData,
  output logic [3:0] fwdPinMask,
  input wire logic bcFrameValid,
  input wire logic [3:0] bcPinData
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic gpio_link_pkg::fwd_mode_t countToMode(input logic [2:0] cnt);
    case (cnt)
      3'h0: countToMode = gpio_link_pkg::FWD_OFF;
      3'h1: countToMode = gpio_link_pkg::FWD_ONE;
      3'h2: countToMode = gpio_link_pkg::FWD_TWO;
      default: countToMode = gpio_link_pkg::FWD_MANY;
    endcase
  endfunction

  function automatic logic [3:0] countToMask(input logic [2:0] cnt);
    case (cnt)
      3'h0: countToMask = 4'h0;
      3'h1: countToMask = 4'h1;
      3'h2: countToMask = 4'h3;
      3'h3: countToMask = 4'h7;
      default: countToMask = 4'hF;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] remoteData_r;
  logic [7:0] dirCtrl_r;
  logic [7:0] fwdCount_r;
  logic [7:0] regRdData_r;
  logic [7:0] regRdData_nxt;
  logic [3:0] inEn;
  logic [3:0] outEn;
  logic [3:0] localVal;
  logic [3:0] remoteSel;
  logic [2:0] countField;
  logic [3:0] pinSync;
  logic [3:0] pinStatus;
  logic [3:0] analogMask;
  logic wrRemote;
  logic wrDir;
  logic wrCount;

  assign inEn = dirCtrl_r[gpio_link_pkg::DIR_IN_LSB +: gpio_link_pkg::NUM_PINS];
  assign outEn = dirCtrl_r[gpio_link_pkg::DIR_OUT_LSB +: gpio_link_pkg::NUM_PINS];
  assign localVal = remoteData_r[gpio_link_pkg::LOCAL_VAL_LSB +: gpio_link_pkg::NUM_PINS];
  assign remoteSel = remoteData_r[gpio_link_pkg::REMOTE_SEL_LSB +: gpio_link_pkg::NUM_PINS];
  assign countField = fwdCount_r[gpio_link_pkg::FWD_COUNT_LSB +: gpio_link_pkg::FWD_COUNT_W];
  assign wrRemote = ce && regWr && (regAddr == gpio_link_pkg::ADDR_REMOTE_DATA);
  assign wrDir = ce && regWr && (regAddr == gpio_link_pkg::ADDR_DIR_CTRL);
  assign wrCount = ce && regWr && (regAddr == gpio_link_pkg::ADDR_FWD_COUNT);

  // Only pins 0 and 1 have the analog sense path
  assign analogMask = {2'b00, analogSenseSel};
  assign analogSenseEn = analogSenseSel;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      remoteData_r <= gpio_link_pkg::REMOTE_DATA_RST;
      dirCtrl_r <= gpio_link_pkg::DIR_CTRL_RST;
      fwdCount_r <= gpio_link_pkg::FWD_COUNT_RST;
    end else begin
      if (wrRemote) remoteData_r <= regWrData;
      if (wrDir) dirCtrl_r <= regWrData;
      if (wrCount) fwdCount_r <= regWrData;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Level visible only with input enable; output pins need both bits
  assign pinStatus = pinSync & inEn & ~analogMask;

  always_comb begin
    case (regAddr)
      gpio_link_pkg::ADDR_REMOTE_DATA: regRdData_nxt = remoteData_r;
      gpio_link_pkg::ADDR_DIR_CTRL: regRdData_nxt = dirCtrl_r;
      gpio_link_pkg::ADDR_FWD_COUNT: regRdData_nxt = fwdCount_r;
      gpio_link_pkg::ADDR_PIN_STATUS: regRdData_nxt = {4'h0, pinStatus};
      default: regRdData_nxt = gpio_link_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      regRdData_r <= 8'h00;
    end else if (ce && regRd) begin
      regRdData_r <= regRdData_nxt;
    end
  end

  assign regRdData = regRdData_r;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic fwdClkSync;
  logic fwdClkPrev_r;
  logic fwdEdge;

  // Pins and the forward frame clock share one synchroniser
  pin_sync3 #(
    .W(5)
  ) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .asyncIn({fwdFrameClk, pinIn}),
    .syncOut({fwdClkSync, pinSync})
  );

  assign fwdEdge = fwdClkSync && !fwdClkPrev_r;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      fwdClkPrev_r <= 1'b0;
    end else if (ce) begin
      fwdClkPrev_r <= fwdClkSync;
    end
  end

  // ----------------------------------------------------------------
  // Forward channel sampling
  // ----------------------------------------------------------------
  gpio_link_pkg::fwd_mode_t fwdMode;
  logic [2:0] fwdPeriod;
  logic [3:0] linkMask;
  logic [2:0] frameCnt_r;
  logic [2:0] frameCnt_nxt;
  logic sampleNow;
  logic [3:0] fwdPinData_r;
  logic [3:0] fwdPinMask_r;
  logic fwdFrameStrobe_r;

  assign fwdMode = countToMode(countField);
  assign linkMask = countToMask(countField);

  always_comb begin
    case (fwdMode)
      gpio_link_pkg::FWD_ONE: fwdPeriod = gpio_link_pkg::FWD_PERIOD_ONE;
      gpio_link_pkg::FWD_TWO: fwdPeriod = gpio_link_pkg::FWD_PERIOD_TWO;
      gpio_link_pkg::FWD_MANY: fwdPeriod = gpio_link_pkg::FWD_PERIOD_MANY;
      default: fwdPeriod = gpio_link_pkg::FWD_PERIOD_ONE;
    endcase
  end

  // Period in frames fixes the per-pin rate against the frame rate
  assign sampleNow = fwdEdge && (frameCnt_r == 3'h0) && (fwdMode != gpio_link_pkg::FWD_OFF);
  assign frameCnt_nxt = (frameCnt_r >= fwdPeriod - 3'h1) ? 3'h0 : frameCnt_r + 3'h1;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      frameCnt_r <= 3'h0;
      fwdPinData_r <= 4'h0;
      fwdPinMask_r <= 4'h0;
      fwdFrameStrobe_r <= 1'b0;
    end else if (ce) begin
      fwdFrameStrobe_r <= fwdEdge;
      if (wrCount) begin
        frameCnt_r <= 3'h0;
      end else if (fwdEdge) begin
        frameCnt_r <= frameCnt_nxt;
      end
      if (sampleNow) begin
        fwdPinData_r <= pinSync & linkMask;
        fwdPinMask_r <= linkMask;
      end else if (fwdEdge) begin
        fwdPinMask_r <= 4'h0;
      end
    end
  end

  assign fwdFrameStrobe = fwdFrameStrobe_r;
  assign fwdPinData = fwdPinData_r;
  assign fwdPinMask = fwdPinMask_r;

  // ----------------------------------------------------------------
  // Back channel and pin drivers
  // ----------------------------------------------------------------
  logic [3:0] remoteVal_r;
  logic [3:0] pinOut_r;
  logic [3:0] pinOut_nxt;

  // Frames come at the back channel rate; any bit may carry frame sync
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      remoteVal_r <= 4'h0;
    end else if (ce && bcFrameValid) begin
      remoteVal_r <= bcPinData;
    end
  end

  assign pinOut_nxt = (remoteSel & remoteVal_r) | (~remoteSel & localVal);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pinOut_r <= 4'h0;
    end else if (ce) begin
      pinOut_r <= pinOut_nxt;
    end
  end

  assign pinOut = pinOut_r;
  assign pinOe = outEn & ~analogMask;
  assign pinPullDown = inEn & ~analogMask;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_status_masked: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && regRd && regAddr == gpio_link_pkg::ADDR_PIN_STATUS) |=>
      (regRdData[7:4] == 4'h0) && ((regRdData[3:0] & ~$past(inEn)) == 4'h0))
    else $error("status bit set for pin without input enable");

  chk_pins_default_in: assert property (@(posedge clock)
    $rose(reset_n) |-> (inEn == 4'hF) && (outEn == 4'h0))
    else $error("pins not inputs after reset");

  chk_pulldown_follows: assert property (@(posedge clock) disable iff (!reset_n)
    (wrDir && regWrData[0] && !analogSenseSel[0]) |=> pinPullDown[0])
    else $error("pull-down missing with input enable");

  chk_driver_off_idle: assert property (@(posedge clock) disable iff (!reset_n)
    (wrDir && regWrData[7:4] == 4'h0) |=> (pinOe == 4'h0))
    else $error("driver on with no output enable");

  chk_oe_from_write: assert property (@(posedge clock) disable iff (!reset_n)
    (wrDir && !analogSenseSel[1]) |=> (pinOe[1] == $past(regWrData[5])))
    else $error("output enable not taken from bit 5");

  chk_one_pin_rate: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && fwdEdge && fwdMode == gpio_link_pkg::FWD_ONE && !wrCount) |=>
      (fwdPinMask == 4'h1) && fwdFrameStrobe)
    else $error("single linked pin not sampled every frame");

  chk_many_spacing: assert property (@(posedge clock) disable iff (!reset_n)
    (sampleNow && ce && !wrCount && fwdMode == gpio_link_pkg::FWD_MANY) |=>
      (frameCnt_r == 3'h1))
    else $error("five-frame period not started");

  chk_sync_only: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && sampleNow) |=> (fwdPinData == ($past(pinSync) & $past(linkMask))))
    else $error("forward data not from synchronised pins");

  chk_remote_to_pin: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && bcFrameValid && remoteSel[0] && !wrRemote) ##1 ce[*1] |=>
      (pinOut[0] == $past(bcPinData[0], 2)))
    else $error("remote value late on pin");

  chk_local_drive: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && !remoteSel[2] && !wrRemote) |=> (pinOut[2] == $past(localVal[2])))
    else $error("local value not driven");

  chk_ce_freeze: assert property (@(posedge clock) disable iff (!reset_n)
    !ce |=> $stable(dirCtrl_r) && $stable(remoteData_r) && $stable(fwdCount_r)
      && $stable(pinOut) && $stable(fwdPinMask))
    else $error("state moved with clock enable low");

  chk_rd_data_hold: assert property (@(posedge clock) disable iff (!reset_n)
    !(ce && regRd) |=> $stable(regRdData))
    else $error("read data changed without a read");

  chk_pulldown_off: assert property (@(posedge clock) disable iff (!reset_n)
    (wrDir && !regWrData[3]) |=> !pinPullDown[3])
    else $error("pull-down left on without input enable");

  chk_oe_only_status: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && regRd && regAddr == gpio_link_pkg::ADDR_PIN_STATUS && outEn[2] && !inEn[2]) |=>
      !regRdData[2])
    else $error("status shown for output-only pin");

  chk_analog_status: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && regRd && regAddr == gpio_link_pkg::ADDR_PIN_STATUS && analogSenseSel[1]) |=>
      !regRdData[1])
    else $error("status shown for analog sense pin");

  chk_count_off: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && fwdEdge && fwdMode == gpio_link_pkg::FWD_OFF) |=>
      fwdFrameStrobe && (fwdPinMask == 4'h0))
    else $error("pins forwarded with count zero");

  chk_two_pin_spacing: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && sampleNow && !wrCount && fwdMode == gpio_link_pkg::FWD_TWO) |=>
      (frameCnt_r == 3'h1) && (fwdPinMask == 4'h3))
    else $error("two-frame period not started");

  chk_strobe_single: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && fwdFrameStrobe) |=> !fwdFrameStrobe)
    else $error("forward strobe longer than one cycle");

  cov_one_linked: cover property (@(posedge clock) disable iff (!reset_n)
    sampleNow && fwdMode == gpio_link_pkg::FWD_ONE);
  cov_two_linked: cover property (@(posedge clock) disable iff (!reset_n)
    sampleNow && fwdMode == gpio_link_pkg::FWD_TWO);
  cov_four_linked: cover property (@(posedge clock) disable iff (!reset_n)
    sampleNow && fwdMode == gpio_link_pkg::FWD_MANY && linkMask == 4'hF);
  cov_frame_sync: cover property (@(posedge clock) disable iff (!reset_n)
    bcFrameValid && remoteSel[3] ##2 $rose(pinOut[3]));
  cov_readback_out: cover property (@(posedge clock) disable iff (!reset_n)
    regRd && regAddr == gpio_link_pkg::ADDR_PIN_STATUS && (inEn & outEn) != 4'h0);

endmodule // serializer_gpio_link_port

// ### test/deser_model.sv
// Deserializer-side partner: forward frame clock and back channel frames
`timescale 1ns/1ps
module deser_model (
  input wire logic clock,
  input wire logic runLink,
  output logic fwdFrameClk,
  output logic bcFrameValid,
  output logic [3:0] bcPinData
);
  // ----------------------------------------------------------------
  // Forward frame clock, 160 ns, idle low between runs
  // ----------------------------------------------------------------
  initial begin
    fwdFrameClk = 1'b0;
    bcFrameValid = 1'b0;
    bcPinData = 4'h0;
    #3;
    forever begin
      #80;
      fwdFrameClk = runLink ? ~fwdFrameClk : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // One back channel frame carrying the remote pin values
  // ----------------------------------------------------------------
  task automatic send_bc(input logic [3:0] v);
    @(posedge clock);
    bcFrameValid <= 1'b1;
    bcPinData <= v;
    @(posedge clock);
    bcFrameValid <= 1'b0;
    bcPinData <= ~v;
  endtask
endmodule // deser_model

// ### test/serializer_gpio_link_port_test.sv
// Self-checking bench for the serializer pin link port
`timescale 1ns/1ps
module serializer_gpio_link_port_test;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [3:0] extVal = 4'h0;
  logic [1:0] analogSenseSel = 2'b00;
  logic runLink = 1'b0;
  logic ce = 1'b1;
  logic [7:0] regRdData;
  logic [3:0] pinOut, pinOe, pinPullDown, fwdPinData, fwdPinMask, bcPinData;
  logic [1:0] analogSenseEn;
  logic fwdFrameClk, fwdFrameStrobe, bcFrameValid;
  wire [3:0] pinPad;
  int fails = 0;
  int compares = 0;

  // Pad level from the driver enable, else the outside world
  assign pinPad = (pinOe & pinOut) | (~pinOe & extVal);
  always #5 clock = ~clock;

  serializer_gpio_link_port i_dut (.clock(clock), .reset_n(reset_n), .ce(ce),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .pinIn(pinPad), .pinOut(pinOut), .pinOe(pinOe),
    .pinPullDown(pinPullDown), .analogSenseSel(analogSenseSel),
    .analogSenseEn(analogSenseEn), .fwdFrameClk(fwdFrameClk),
    .fwdFrameStrobe(fwdFrameStrobe), .fwdPinData(fwdPinData), .fwdPinMask(fwdPinMask),
    .bcFrameValid(bcFrameValid), .bcPinData(bcPinData));
  deser_model i_partner (.clock(clock), .runLink(runLink), .fwdFrameClk(fwdFrameClk),
    .bcFrameValid(bcFrameValid), .bcPinData(bcPinData));

  // ----------------------------------------------------------------
  // Access and checking tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    @(posedge clock);
    #1;
    check(regRdData, exp, what);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_strobe;
    for (int n = 0; n < 60; n++) begin
      @(posedge clock);
      #1;
      if (fwdFrameStrobe === 1'b1) return;
    end
    fails++;
    $display("unexpected at %0t ns: no forward frame", $time);
    close_out;
  endtask
  task automatic fwd_count(input logic [3:0] m, input int fresh);
    int seen;
    seen = 0;
    wait_strobe;
    for (int k = 0; k < 10; k++) begin
      wait_strobe;
      if (fwdPinMask !== 4'h0) begin
        seen++;
        check({4'h0, fwdPinMask}, {4'h0, m}, "forward mask");
        check({4'h0, fwdPinData & m}, {4'h0, extVal & m}, "forward data");
      end
    end
    check(8'(seen), 8'(fresh), "fresh frames");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [3:0] maskTab [6] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'hF};
    int freshTab [6] = '{0, 10, 5, 2, 2, 2};
    logic [3:0] bcTab [3] = '{4'h4, 4'h8, 4'h0};
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    expect_reg(gpio_link_pkg::ADDR_DIR_CTRL, 8'h0F, "direction reset");
    expect_reg(gpio_link_pkg::ADDR_REMOTE_DATA, 8'h00, "remote reset");
    expect_reg(gpio_link_pkg::ADDR_FWD_COUNT, 8'h00, "count reset");
    expect_reg(8'h40, 8'h00, "unmapped read");
    check({pinOe, pinPullDown}, 8'h0F, "pins after reset");
    $display("done: reset values");
    extVal <= 4'hA;
    settle(8);
    expect_reg(gpio_link_pkg::ADDR_PIN_STATUS, 8'h0A, "input status");
    reg_write(gpio_link_pkg::ADDR_DIR_CTRL, 8'h03);
    expect_reg(gpio_link_pkg::ADDR_PIN_STATUS, 8'h02, "partial inputs");
    check({4'h0, pinPullDown}, 8'h03, "pull partial");
    reg_write(gpio_link_pkg::ADDR_PIN_STATUS, 8'hFF);
    expect_reg(gpio_link_pkg::ADDR_PIN_STATUS, 8'h02, "status read only");
    analogSenseSel <= 2'b10;
    settle(2);
    check({analogSenseEn, 2'b00, pinPullDown}, 8'h81, "analog sense");
    expect_reg(gpio_link_pkg::ADDR_PIN_STATUS, 8'h00, "analog status");
    analogSenseSel <= 2'b00;
    $display("done: input status");
    reg_write(gpio_link_pkg::ADDR_DIR_CTRL, 8'hF0);
    reg_write(gpio_link_pkg::ADDR_REMOTE_DATA, 8'h05);
    settle(8);
    check({pinOe, pinOut}, 8'hF5, "local drive");
    check({4'h0, pinPullDown}, 8'h00, "pull off");
    expect_reg(gpio_link_pkg::ADDR_PIN_STATUS, 8'h00, "output only status");
    reg_write(gpio_link_pkg::ADDR_DIR_CTRL, 8'hFF);
    settle(8);
    expect_reg(gpio_link_pkg::ADDR_PIN_STATUS, 8'h05, "readback");
    check({4'h0, pinPullDown}, 8'h0F, "pull while driving");
    reg_write(gpio_link_pkg::ADDR_DIR_CTRL, 8'h00);
    settle(1);
    check({pinOe, pinPullDown}, 8'h00, "pins idle");
    $display("done: output control");
    reg_write(gpio_link_pkg::ADDR_DIR_CTRL, 8'hF0);
    reg_write(gpio_link_pkg::ADDR_REMOTE_DATA, 8'hC3);
    foreach (bcTab[i]) begin
      i_partner.send_bc(bcTab[i]);
      settle(3);
      check({4'h0, pinOut}, {4'h0, bcTab[i][3:2], 2'b11}, "remote drive");
    end
    $display("done: back channel");
    ce <= 1'b0;
    reg_write(gpio_link_pkg::ADDR_REMOTE_DATA, 8'h00);
    i_partner.send_bc(4'hF);
    ce <= 1'b1;
    expect_reg(gpio_link_pkg::ADDR_REMOTE_DATA, 8'hC3, "frozen write");
    check({4'h0, pinOut}, 8'h03, "frozen remote");
    $display("done: clock enable");
    reg_write(gpio_link_pkg::ADDR_DIR_CTRL, 8'h0F);
    extVal <= 4'hB;
    runLink <= 1'b1;
    for (int c = 0; c < 6; c++) begin
      reg_write(gpio_link_pkg::ADDR_FWD_COUNT, 8'(c));
      fwd_count(maskTab[c], freshTab[c]);
    end
    runLink <= 1'b0;
    $display("done: forward link");
    close_out;
  end
endmodule // serializer_gpio_link_port_test
